// [test/serial_dac_model.sv]
// Behavioural model of the serial-input DAC that the controller drives.
`timescale 1ns/100ps
`default_nettype none
module serial_dac_model (
   input  wire logic        serial_code_in,
   input  wire logic        shift_clk,
   input  wire logic        load_n,
   output logic [11:0]      dac_code
);
   logic [11:0] shift_ff;

   // The device has no reset, so the shift register powers up unknown.
   always @(posedge shift_clk) begin
      if (load_n) begin
         shift_ff <= {shift_ff[10:0], serial_code_in};
      end
   end

   // The DAC register follows the shift register while the strobe is low and holds otherwise.
   always_latch begin
      if (!load_n) begin
         dac_code <= shift_ff;
      end
   end
endmodule
`default_nettype wire

// [test/serial_dac_write_port_tb.sv]
// Self-checking testbench for the serial DAC write controller.
`timescale 1ns/100ps
`default_nettype none
`include "dac_write_defines.svh"
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin n_mismatch++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end
module serial_dac_write_port_tb;
   logic              clk_sys;
   logic              rst;
   logic              code_valid;
   logic              code_ready;
   logic [11:0]       code_data;
   logic              ser;
   logic              shift_clk;
   logic              load_n;
   logic [15:0]       bus_addr;
   logic [7:0]        bus_wdata;
   logic              busy;
   logic [11:0]       dac_code;
   logic [11:0]       exp_q[$];
   logic [11:0]       exp_w;
   logic              prev_sclk;
   logic              prev_ser;
   logic              prev_load;
   logic              refused;
   int                rise_cnt;
   int                low_cnt;
   int                n_mismatch;
   int                cmp_count;

   dac_write_host DUT (.clk_sys(clk_sys), .rst(rst), .code_valid(code_valid), .code_ready(code_ready),
      .code_data(code_data), .host_serial_out_line(ser), .shift_clk(shift_clk), .load_n(load_n),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .busy(busy));

   serial_dac_model dev (.serial_code_in(ser), .shift_clk(shift_clk), .load_n(load_n), .dac_code(dac_code));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Watches the device pins at the falling edge, where they are settled, and checks every loaded word in order.
   always @(negedge clk_sys) begin
      if (rst) begin
         rise_cnt = 0;
         low_cnt = 0;
      end else begin
         if (shift_clk && !prev_sclk && bus_addr === `ADDR_SHIFT) rise_cnt++;
         if (shift_clk && prev_sclk) `CHK(ser, prev_ser)
         if (bus_addr === `ADDR_SHIFT) `CHK(bus_wdata, {ser, 7'h00})
         if (!load_n) begin
            `CHK({shift_clk, bus_addr}, {1'b0, `ADDR_LOAD})
            low_cnt++;
         end
         if (!load_n && prev_load) `CHK(rise_cnt, 12)
         if (load_n && !prev_load) begin
            exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : ~dac_code;
            `CHK(low_cnt, `STROBE_CYC)
            `CHK(dac_code, exp_w)
            rise_cnt = 0;
            low_cnt = 0;
         end
      end
      prev_sclk <= shift_clk;
      prev_ser <= ser;
      prev_load <= load_n;
   end

   task print_verdict;
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task timeout;
      n_mismatch++;
      print_verdict();
   endtask

   task send(input logic [11:0] w);
      int i;
      @(negedge clk_sys);
      code_valid = 1'b1;
      code_data = w;
      for (i = 0; i < 2000; i++) begin
         #1;
         if (code_ready === 1'b1) break;
         refused = 1'b1;
         @(negedge clk_sys);
      end
      if (i == 2000) timeout();
      @(posedge clk_sys);
      exp_q.push_back(w);
      @(negedge clk_sys);
      code_valid = 1'b0;
   endtask

   task drain;
      int i;
      for (i = 0; i < 8000; i++) begin
         @(negedge clk_sys);
         if (busy === 1'b0 && exp_q.size() == 0) break;
      end
      if (i == 8000) timeout();
   endtask

   task t_reset_values;
      `CHK({shift_clk, load_n, ser, busy, code_ready}, 5'b11101)
      `CHK({bus_addr, bus_wdata}, 24'h000000)
   endtask

   task t_single;
      send(12'hA5C);
      drain();
      repeat (40) @(negedge clk_sys);
      `CHK(dac_code, 12'hA5C)
   endtask

   task t_back_to_back;
      logic [11:0] codes[4];
      codes = '{12'hFFF, 12'h000, 12'h801, 12'h7FE};
      refused = 1'b0;
      foreach (codes[k]) send(codes[k]);
      `CHK(refused, 1'b1)
      drain();
      `CHK(dac_code, 12'h7FE)
   endtask

   task t_mid_reset;
      send(12'h123);
      repeat (100) @(negedge clk_sys);
      rst = 1'b1;
      exp_q.delete();
      repeat (2) @(negedge clk_sys);
      t_reset_values();
      rst = 1'b0;
      send(12'h3C6);
      drain();
      `CHK(dac_code, 12'h3C6)
   endtask

   initial begin
      rst = 1'b1;
      code_valid = 1'b0;
      code_data = 12'h000;
      n_mismatch = 0;
      cmp_count = 0;
      refused = 1'b0;
      prev_sclk = 1'b1;
      prev_ser = 1'b1;
      prev_load = 1'b1;
      repeat (12) @(negedge clk_sys);
      t_reset_values();
      rst = 1'b0;
      t_single();
      t_back_to_back();
      t_mid_reset();
      print_verdict();
   end
endmodule
`default_nettype wire

// [verilog/code_skid_buffer.sv]
// Two-entry buffer for code words.
`timescale 1ns/100ps
`default_nettype none
`include "dac_write_defines.svh"
module code_skid_buffer
   import dac_write_pkg::*;
(
   input  wire logic   clk_sys,
   input  wire logic   rst,
   input  wire logic   in_valid,
   output logic        in_ready,
   input  wire logic [`CODE_W-1:0] in_data,
   code_stream_if.src  out
);
   logic [`CODE_W-1:0] mem_ff [2];
   logic [`CODE_W-1:0] nxt_mem [2];
   logic               rd_ff, wr_ff, nxt_rd, nxt_wr;
   logic [1:0]         cnt_ff, nxt_cnt;
   logic               push, pop;

   assign in_ready  = (cnt_ff != 2'h2);
   assign out.valid = (cnt_ff != 2'h0);
   assign out.data  = mem_ff[rd_ff];
   assign push      = in_valid && in_ready;
   assign pop       = out.valid && out.ready;

   always_comb begin
      nxt_mem = mem_ff;
      nxt_wr  = wr_ff;
      nxt_rd  = rd_ff;
      nxt_cnt = cnt_ff;
      if (push) begin
         nxt_mem[wr_ff] = in_data;
         nxt_wr = ~wr_ff;
      end
      if (pop) begin
         nxt_rd = ~rd_ff;
      end
      if (push && !pop) begin
         nxt_cnt = cnt_ff + 2'h1;
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - 2'h1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mem_ff[0] <= 12'h000;
         mem_ff[1] <= 12'h000;
         rd_ff     <= 1'b0;
         wr_ff     <= 1'b0;
         cnt_ff    <= 2'h0;
      end else begin
         mem_ff <= nxt_mem;
         rd_ff  <= nxt_rd;
         wr_ff  <= nxt_wr;
         cnt_ff <= nxt_cnt;
      end
   end
endmodule
`default_nettype wire

// [verilog/code_stream_if.sv]
// Valid/ready carrier for one 12-bit code word.
`timescale 1ns/100ps
`default_nettype none
interface code_stream_if;
   logic        valid;
   logic        ready;
   logic [11:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// [verilog/dac_write_defines.svh]
// Constants for the serial DAC write controller.
`ifndef DAC_WRITE_DEFINES_SVH
`define DAC_WRITE_DEFINES_SVH
`define CODE_W          12
`define CODE_MSB        11
`define BYTE_W          8
`define HI_NIBBLE_W     4
`define BIT_CNT_W       4
`define BIT_CNT_LAST    4'hB
`define BIT_CNT_ZERO    4'h0
`define HALF_NS         50
`define CLK_NS          5
`define HALF_CYC        ((`HALF_NS + `CLK_NS - 1) / `CLK_NS)
`define DIV_W           8
`define DIV_ZERO        8'h00
`define ADDR_W          16
`define ADDR_SHIFT      16'h8000
`define ADDR_LOAD       16'hA000
`define ADDR_HI_BYTE    16'h0000
`define ADDR_LO_BYTE    16'h0001
`define STROBE_CYC      8
`endif

// [verilog/dac_write_host.sv]
// Host controller that shifts 12-bit codes into a serial DAC and loads them.
// Contract
// - Host drives each serial bit on its own serial output line.
// - One shift clock pulse per decoded write to the clocking address.
// - Write to the transfer address drives the transfer strobe low.
// - Code is held right-justified in two 8-bit working registers.
// - Serial stream is built from successive writes, one bit each.
// - The top data bit of each write is the serial input value.
// - Four MSBs in low nibble of first byte, eight LSBs next.
// - Shift clock pulse on every write to the clocking address.
// - Write to the transfer address pulses the strobe low to update.
// - Strobe stays high until every bit has been shifted.
// - Data and strobe change with the falling edge of shift clock; the strobe's rise and each later word's MSB come with the clock already low.
`timescale 1ns/100ps
`default_nettype none
`include "dac_write_defines.svh"
module dac_write_host
   import dac_write_pkg::*;
(
   input  wire logic               clk_sys,
   input  wire logic               rst,
   input  wire logic               code_valid,
   output logic                    code_ready,
   input  wire logic [`CODE_W-1:0] code_data,
   output logic                    host_serial_out_line,
   output logic                    shift_clk,
   output logic                    load_n,
   output logic [`ADDR_W-1:0]      bus_addr,
   output logic [`BYTE_W-1:0]      bus_wdata,
   output logic                    busy
);
   code_stream_if buf_if ();

   wr_state_t               st_ff, nxt_st;
   logic [`BYTE_W-1:0]      hi_ff, nxt_hi;
   logic [`BYTE_W-1:0]      lo_ff, nxt_lo;
   logic [`BIT_CNT_W-1:0]   bit_ff, nxt_bit;
   logic                    sdo_ff, nxt_sdo;
   logic                    sck_ff, nxt_sck;
   logic                    ld_n_ff, nxt_ld_n;
   logic [`ADDR_W-1:0]      addr_ff, nxt_addr;
   logic [`BYTE_W-1:0]      wdata_ff, nxt_wdata;
   logic [3:0]              ldc_ff, nxt_ldc;
   logic                    tick, run;

   function automatic logic [`BYTE_W-1:0] bit_byte(input logic b);
      bit_byte = {b, 7'h00};
   endfunction

   function automatic logic pick_bit(input logic [`BYTE_W-1:0] hi, input logic [`BYTE_W-1:0] lo,
                                     input logic [`BIT_CNT_W-1:0] idx);
      logic [`CODE_W-1:0] code;
      code = {hi[`HI_NIBBLE_W-1:0], lo};
      pick_bit = code[`CODE_MSB - idx];
   endfunction

   code_skid_buffer u_buf (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .in_valid (code_valid),
      .in_ready (code_ready),
      .in_data  (code_data),
      .out      (buf_if.src)
   );

   assign run = (st_ff != ST_IDLE);

   half_period_divider u_div (
      .clk_sys (clk_sys),
      .rst     (rst),
      .run     (run),
      .tick    (tick)
   );

   assign buf_if.ready         = (st_ff == ST_IDLE);
   assign host_serial_out_line = sdo_ff;
   assign shift_clk            = sck_ff;
   assign load_n               = ld_n_ff;
   assign bus_addr             = addr_ff;
   assign bus_wdata            = wdata_ff;
   assign busy                 = run;

   always_comb begin
      nxt_st    = st_ff;
      nxt_hi    = hi_ff;
      nxt_lo    = lo_ff;
      nxt_bit   = bit_ff;
      nxt_sdo   = sdo_ff;
      nxt_sck   = sck_ff;
      nxt_ld_n  = ld_n_ff;
      nxt_addr  = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_ldc   = ldc_ff;
      unique case (st_ff)
         ST_IDLE: begin
            if (buf_if.valid) begin
               nxt_hi    = {4'h0, buf_if.data[`CODE_W-1:`BYTE_W]};
               nxt_lo    = buf_if.data[`BYTE_W-1:0];
               nxt_bit   = `BIT_CNT_ZERO;
               nxt_sdo   = buf_if.data[`CODE_MSB];
               nxt_wdata = bit_byte(buf_if.data[`CODE_MSB]);
               nxt_addr  = `ADDR_SHIFT;
               nxt_sck   = 1'b0;
               nxt_st    = ST_LOW;
            end
         end
         ST_LOW: begin
            if (tick) begin
               nxt_sck = 1'b1;
               nxt_st  = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (tick) begin
               nxt_sck = 1'b0;
               if (bit_ff == `BIT_CNT_LAST) begin
                  nxt_ld_n = 1'b0;
                  nxt_addr = `ADDR_LOAD;
                  nxt_ldc  = 4'h0;
                  nxt_st   = ST_LOAD;
               end else begin
                  nxt_bit   = bit_ff + 4'h1;
                  nxt_sdo   = pick_bit(hi_ff, lo_ff, bit_ff + 4'h1);
                  nxt_wdata = bit_byte(pick_bit(hi_ff, lo_ff, bit_ff + 4'h1));
                  nxt_st    = ST_LOW;
               end
            end
         end
         ST_LOAD: begin
            nxt_ldc = ldc_ff + 4'h1;
            if (ldc_ff == 4'(`STROBE_CYC - 1)) begin
               nxt_ld_n = 1'b1;
               nxt_st   = ST_DONE;
            end
         end
         ST_DONE: begin
            nxt_addr = `ADDR_HI_BYTE;
            nxt_st   = ST_IDLE;
         end
         default: begin
            nxt_st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_ff    <= ST_IDLE;
         hi_ff    <= 8'h00;
         lo_ff    <= 8'h00;
         bit_ff   <= 4'h0;
         sdo_ff   <= 1'b1;
         sck_ff   <= 1'b1;
         ld_n_ff  <= 1'b1;
         addr_ff  <= 16'h0000;
         wdata_ff <= 8'h00;
         ldc_ff   <= 4'h0;
      end else begin
         st_ff    <= nxt_st;
         hi_ff    <= nxt_hi;
         lo_ff    <= nxt_lo;
         bit_ff   <= nxt_bit;
         sdo_ff   <= nxt_sdo;
         sck_ff   <= nxt_sck;
         ld_n_ff  <= nxt_ld_n;
         addr_ff  <= nxt_addr;
         wdata_ff <= nxt_wdata;
         ldc_ff   <= nxt_ldc;
      end
   end

   property p_load_only_clock_low;
      @(posedge clk_sys) disable iff (rst) !load_n |-> !shift_clk;
   endproperty
   a_load_only_clock_low: assert property (p_load_only_clock_low) else $error("Strobe low with clock high.");

   property p_data_stable_high;
      @(posedge clk_sys) disable iff (rst) (shift_clk && $past(shift_clk)) |-> $stable(host_serial_out_line);
   endproperty
   a_data_stable_high: assert property (p_data_stable_high) else $error("Data changed while clock high.");

   property p_strobe_after_fall;
      @(posedge clk_sys) disable iff (rst) $fell(load_n) |-> $fell(shift_clk);
   endproperty
   a_strobe_after_fall: assert property (p_strobe_after_fall) else $error("Strobe not on clock fall.");

   property p_data_on_fall;
      @(posedge clk_sys) disable iff (rst) ($changed(host_serial_out_line) && st_ff != ST_LOW) |-> 0;
   endproperty
   a_data_on_fall: assert property (p_data_on_fall) else $error("Data changed outside a fall.");

   property p_rise_after_low;
      @(posedge clk_sys) disable iff (rst) $rose(shift_clk) |-> addr_ff == `ADDR_SHIFT;
   endproperty
   a_rise_after_low: assert property (p_rise_after_low) else $error("Clock rise outside clock address.");

   property p_load_addr;
      @(posedge clk_sys) disable iff (rst) !load_n |-> addr_ff == `ADDR_LOAD;
   endproperty
   a_load_addr: assert property (p_load_addr) else $error("Strobe low outside load address.");

   property p_load_width;
      @(posedge clk_sys) disable iff (rst) $fell(load_n) |-> !load_n [*8] ##1 load_n;
   endproperty
   a_load_width: assert property (p_load_width) else $error("Strobe width wrong.");

   property p_wdata_bit;
      @(posedge clk_sys) disable iff (rst) run |-> bus_wdata[7] == host_serial_out_line;
   endproperty
   a_wdata_bit: assert property (p_wdata_bit) else $error("Bus bit differs from serial line.");

   property p_first_bit;
      @(posedge clk_sys) disable iff (rst) (st_ff == ST_IDLE && buf_if.valid)
         |=> host_serial_out_line == $past(buf_if.data[11]);
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("First bit is not the MSB.");

   c_word:  cover property (@(posedge clk_sys) disable iff (rst) $rose(load_n));
   c_stall: cover property (@(posedge clk_sys) disable iff (rst) code_valid && !code_ready);
   c_back:  cover property (@(posedge clk_sys) disable iff (rst) st_ff == ST_DONE && buf_if.valid);
endmodule
`default_nettype wire

// [verilog/dac_write_pkg.sv]
// Types for the serial DAC write controller.
package dac_write_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_LOW   = 3'b001,
      ST_HIGH  = 3'b010,
      ST_LOAD  = 3'b011,
      ST_DONE  = 3'b100
   } wr_state_t;
endpackage

// [verilog/half_period_divider.sv]
// Enable divider giving one pulse per half shift-clock period.
`timescale 1ns/100ps
`default_nettype none
`include "dac_write_defines.svh"
module half_period_divider (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic run,
   output logic      tick
);
   logic [`DIV_W-1:0] cnt_ff, nxt_cnt;
   localparam logic [`DIV_W-1:0] LAST = 8'(`HALF_CYC - 1);

   assign tick = run && (cnt_ff == LAST);

   always_comb begin
      nxt_cnt = `DIV_ZERO;
      if (run && cnt_ff != LAST) begin
         nxt_cnt = cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_ff <= `DIV_ZERO;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule
`default_nettype wire
